// ==== rtl/scd_divider.sv ====
// Glitch-free source switch and power-of-two system clock divider.
`timescale 1ns/10ps
module scd_divider (
  input wire logic clk_i,           // Block clock.
  input wire logic srst_i,          // Synchronous reset, active high.
  input wire logic ce_i,            // Clock enable.
  input wire logic int_tick_i,      // Post-scaled internal oscillator edge.
  input wire logic ext_tick_i,      // External oscillator edge.
  input wire logic [2:0] src_sel_i, // Requested source code.
  input wire logic [2:0] div_i,     // Requested divider code.
  output logic sys_tick_o,          // System clock edge pulse.
  output logic ready_o,             // Requested division is applied.
  output logic src_ext_o            // External source is in use.
);

  typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} scd_sw_t;

  scd_sw_t sw_state;
  logic [2:0] applied;
  logic [6:0] cnt;
  logic target_ext;
  logic sys_tick;
  logic src_tick;
  logic old_tick;
  logic new_tick;
  logic want_ext;
  logic want_valid;
  logic primed;

  function automatic logic [6:0] div_last(input logic [2:0] code);
    div_last = 7'((8'h01 << code) - 8'h01);
  endfunction : div_last

  assign src_tick = src_ext_o ? ext_tick_i : int_tick_i;
  assign old_tick = src_ext_o ? ext_tick_i : int_tick_i;
  assign new_tick = target_ext ? ext_tick_i : int_tick_i;
  assign want_ext = (src_sel_i == scd_pkg::SRC_EXTERNAL);
  assign want_valid = (src_sel_i == scd_pkg::SRC_INTERNAL) || want_ext;
  assign sys_tick_o = sys_tick;
  // Ready stays low after reset until the first source edge applies a code.
  assign ready_o = primed && (applied == div_i);

  // ----------------------------------------------------------------
  // Source switch: one old edge, then one new edge, then swap.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sw_state <= SW_IDLE;
      src_ext_o <= 1'b0;
      target_ext <= 1'b0;
    end
    else if (ce_i)
    begin
      case (sw_state)
        SW_IDLE:
        begin
          if (want_valid && (want_ext != src_ext_o))
          begin
            target_ext <= want_ext;
            sw_state <= SW_OLD;
          end
        end
        SW_OLD:
        begin
          if (old_tick)
          begin
            sw_state <= SW_NEW;
          end
        end
        SW_NEW:
        begin
          if (new_tick)
          begin
            src_ext_o <= target_ext;
            sw_state <= SW_IDLE;
          end
        end
        default:
        begin
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Divider: a new code is taken only at a period end, or at the first source edge after reset or a source switch.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt <= 7'h00;
      applied <= scd_pkg::DIV_RESET;
      sys_tick <= 1'b0;
      primed <= 1'b0;
    end
    else if (ce_i)
    begin
      sys_tick <= 1'b0;
      if (sw_state == SW_NEW && new_tick)
      begin
        cnt <= 7'h00;
      end
      else if (src_tick)
      begin
        if (cnt == 7'h00)
        begin
          sys_tick <= 1'b1;
          applied <= div_i;
          primed <= 1'b1;
          cnt <= div_last(div_i);
        end
        else
        begin
          cnt <= cnt - 7'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence old_edge_s;
    sw_state == SW_OLD && old_tick;
  endsequence

  sequence new_edge_s;
    sw_state == SW_NEW && new_tick;
  endsequence

  div_apply_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    (src_tick && cnt == 7'h00 && !(sw_state == SW_NEW && new_tick)) |=>
      (applied == $past(div_i) && cnt == div_last($past(div_i))))
    else $error("Divider code not taken at period end.");

  tick_cause_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    sys_tick |-> ($past(src_tick) && $past(cnt) == 7'h00))
    else $error("System tick without a source edge at count zero.");

  switch_seq_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    old_edge_s ##[1:8] new_edge_s |=> (src_ext_o == $past(target_ext)))
    else $error("Source switch did not complete after old and new edges.");

  reset_state_a: assert property (@(posedge clk_i)
    $past(srst_i) |-> (!src_ext_o && applied == scd_pkg::DIV_RESET && !sys_tick && !ready_o))
    else $error("Divider not at internal source and divide by one after reset.");

endmodule : scd_divider

// ==== rtl/scd_pkg.sv ====
// Constants shared by the system clock select and divider block.
package scd_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'hBD;
  localparam logic [7:0] ADDR_OSC_CAL = 8'hBF;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'hA9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_READY_BIT = 7;
  localparam int SEL_DIV_LSB = 4;
  localparam int SEL_RESERVED_BIT = 3;
  localparam int SEL_SRC_LSB = 0;
  localparam int CTL_SPREAD_BIT = 3;
  localparam int CTL_POST_LSB = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_INTERNAL = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL = 3'h1;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [1:0] POST_DIV8 = 2'h0;
  localparam logic [1:0] POST_DIV4 = 2'h1;
  localparam logic [1:0] POST_DIV2 = 2'h2;
  localparam logic [1:0] POST_DIV1 = 2'h3;
  localparam logic [1:0] POST_RESET = POST_DIV8;
  localparam logic SPREAD_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Spread spectrum timing
  // ----------------------------------------------------------------
  localparam int SS_UPDATE_TICKS = 32;
  localparam int SS_MAX_STEPS = 3;
  localparam int SS_PERIOD_TICKS = 384;
  localparam int SS_PHASES = SS_PERIOD_TICKS / SS_UPDATE_TICKS;

endpackage : scd_pkg

// ==== rtl/scd_top.sv ====
// System clock select, divider, internal oscillator trim and dithering.
`timescale 1ns/10ps
module scd_top (
  input wire logic CLOCK_I,             // Block clock, 200 MHz.
  input wire logic SRST_I,              // Synchronous reset, active high.
  input wire logic CE_I,                // Clock enable; low freezes all state.
  input wire logic INT_OSC_TICK_I,      // Internal oscillator edge pulse.
  input wire logic EXT_OSC_TICK_I,      // External oscillator edge pulse.
  input wire logic [7:0] FACTORY_TRIM_I, // Factory period trim value.
  input wire logic [7:0] SFR_ADDR_I,    // Special function register address.
  input wire logic [7:0] SFR_WDATA_I,   // Write data.
  input wire logic SFR_WR_I,            // Write strobe.
  input wire logic SFR_RD_I,            // Read strobe.
  output logic [7:0] SFR_RDATA_O,       // Read data, one cycle after strobe.
  output logic SYSCLK_TICK_O,           // System clock edge pulse.
  output logic SRC_EXT_O,               // External source in use.
  output logic [7:0] OSC_TRIM_O,        // Oscillator period trim.
  output logic [2:0] SS_OFFSET_O        // Signed dither offset in steps.
);

  logic [2:0] source_select_field;
  logic [2:0] sysclk_divider_field;
  logic divider_ready_flag;
  logic [7:0] osc_period_trim;
  logic spread_spectrum_enable;
  logic [1:0] internal_osc_postscale;
  logic [2:0] post_cnt;
  logic [2:0] post_last;
  logic post_tick;
  logic [4:0] ss_cnt;
  logic [3:0] ss_phase;
  logic ss_update;
  logic ss_up;
  logic signed [2:0] ss_off;
  logic [7:0] next_rdata;

  localparam logic signed [2:0] SS_TOP = 3'(scd_pkg::SS_MAX_STEPS);
  localparam logic signed [2:0] SS_BOTTOM = -3'(scd_pkg::SS_MAX_STEPS);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      source_select_field <= scd_pkg::SRC_RESET;
      sysclk_divider_field <= scd_pkg::DIV_RESET;
    end
    else if (CE_I && SFR_WR_I && SFR_ADDR_I == scd_pkg::ADDR_CLOCK_SELECT)
    begin
      source_select_field <= SFR_WDATA_I[scd_pkg::SEL_SRC_LSB +: 3];
      sysclk_divider_field <= SFR_WDATA_I[scd_pkg::SEL_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      osc_period_trim <= FACTORY_TRIM_I;
    end
    else if (CE_I && SFR_WR_I && SFR_ADDR_I == scd_pkg::ADDR_OSC_CAL)
    begin
      osc_period_trim <= SFR_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      spread_spectrum_enable <= scd_pkg::SPREAD_RESET;
      internal_osc_postscale <= scd_pkg::POST_RESET;
    end
    else if (CE_I && SFR_WR_I && SFR_ADDR_I == scd_pkg::ADDR_OSC_CONTROL)
    begin
      spread_spectrum_enable <= SFR_WDATA_I[scd_pkg::CTL_SPREAD_BIT];
      internal_osc_postscale <= SFR_WDATA_I[scd_pkg::CTL_POST_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    case (SFR_ADDR_I)
      scd_pkg::ADDR_CLOCK_SELECT:
      begin
        next_rdata[scd_pkg::SEL_READY_BIT] = divider_ready_flag;
        next_rdata[scd_pkg::SEL_DIV_LSB +: 3] = sysclk_divider_field;
        next_rdata[scd_pkg::SEL_RESERVED_BIT] = 1'b0;
        next_rdata[scd_pkg::SEL_SRC_LSB +: 3] = source_select_field;
      end
      scd_pkg::ADDR_OSC_CAL:
      begin
        next_rdata = osc_period_trim;
      end
      scd_pkg::ADDR_OSC_CONTROL:
      begin
        next_rdata[scd_pkg::CTL_SPREAD_BIT] = spread_spectrum_enable;
        next_rdata[scd_pkg::CTL_POST_LSB +: 2] = internal_osc_postscale;
      end
      default:
      begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      SFR_RDATA_O <= 8'h00;
    end
    else if (CE_I && SFR_RD_I)
    begin
      SFR_RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Internal oscillator post-scaler
  // ----------------------------------------------------------------
  always_comb
  begin
    case (internal_osc_postscale)
      scd_pkg::POST_DIV8: post_last = 3'h7;
      scd_pkg::POST_DIV4: post_last = 3'h3;
      scd_pkg::POST_DIV2: post_last = 3'h1;
      scd_pkg::POST_DIV1: post_last = 3'h0;
      default: post_last = 3'h7;
    endcase
  end

  assign post_tick = INT_OSC_TICK_I && (post_cnt >= post_last);

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      post_cnt <= 3'h0;
    end
    else if (CE_I && INT_OSC_TICK_I)
    begin
      post_cnt <= post_tick ? 3'h0 : post_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Spread spectrum triangle
  // ----------------------------------------------------------------
  assign ss_update = INT_OSC_TICK_I && (ss_cnt == 5'(scd_pkg::SS_UPDATE_TICKS - 1));

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I || (CE_I && !spread_spectrum_enable))
    begin
      ss_cnt <= 5'h00;
      ss_phase <= 4'h0;
      ss_up <= 1'b1;
      ss_off <= 3'sh0;
    end
    else if (CE_I && INT_OSC_TICK_I)
    begin
      ss_cnt <= ss_cnt + 5'h01;
      if (ss_update)
      begin
        ss_phase <= (ss_phase == 4'(scd_pkg::SS_PHASES - 1)) ? 4'h0 : ss_phase + 4'h1;
        if (ss_up)
        begin
          ss_up <= (ss_off + 3'sh1) != SS_TOP;
          ss_off <= (ss_off == SS_TOP) ? ss_off - 3'sh1 : ss_off + 3'sh1;
        end
        else
        begin
          ss_up <= (ss_off - 3'sh1) == SS_BOTTOM;
          ss_off <= (ss_off == SS_BOTTOM) ? ss_off + 3'sh1 : ss_off - 3'sh1;
        end
      end
    end
  end

  assign OSC_TRIM_O = osc_period_trim;
  assign SS_OFFSET_O = ss_off;

  // ----------------------------------------------------------------
  // Source switch and divider
  // ----------------------------------------------------------------
  scd_divider u_divider (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .int_tick_i(post_tick),
    .ext_tick_i(EXT_OSC_TICK_I),
    .src_sel_i(source_select_field),
    .div_i(sysclk_divider_field),
    .sys_tick_o(SYSCLK_TICK_O),
    .ready_o(divider_ready_flag),
    .src_ext_o(SRC_EXT_O)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  post_reset_a: assert property (@(posedge CLOCK_I)
    $past(SRST_I) |-> (internal_osc_postscale == scd_pkg::POST_DIV8 && !spread_spectrum_enable))
    else $error("Post-scaler or spread enable wrong after reset.");

  post_ratio_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I)
    (post_tick && internal_osc_postscale == scd_pkg::POST_DIV4) |-> post_cnt == 3'h3)
    else $error("Divide by four post-scale edge at wrong count.");

  ss_range_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (ss_off <= SS_TOP) && (ss_off >= SS_BOTTOM))
    else $error("Dither offset beyond three steps.");

  ss_step_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I)
    (spread_spectrum_enable && !ss_update) |=> $stable(ss_off))
    else $error("Dither offset moved between updates.");

  ss_period_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I)
    (spread_spectrum_enable && ss_update && ss_phase == 4'(scd_pkg::SS_PHASES - 1))
      |=> (ss_off == 3'sh0 || !spread_spectrum_enable))
    else $error("Triangle did not return to centre after one period.");

  reserved_bit_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I)
    (SFR_RD_I && SFR_ADDR_I == scd_pkg::ADDR_CLOCK_SELECT)
      |=> !SFR_RDATA_O[scd_pkg::SEL_RESERVED_BIT])
    else $error("Reserved select bit read as one.");

  ready_clear_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I || !CE_I)
    (SFR_WR_I && SFR_ADDR_I == scd_pkg::ADDR_CLOCK_SELECT
      && SFR_WDATA_I[scd_pkg::SEL_DIV_LSB +: 3] != sysclk_divider_field
      && divider_ready_flag && !SYSCLK_TICK_O)
      |=> !divider_ready_flag)
    else $error("Ready flag set right after a new divider code.");

endmodule : scd_top

// ==== sim/scd_top_tb.sv ====
// Self-checking testbench for the system clock select and divider block.
`timescale 1ns/10ps
module scd_top_tb;
  logic clk, srst, ce, int_tick, ext_tick, wr, rd, sys_tick, src_ext;
  logic [7:0] trim, addr, wdata, rdata, osc_trim;
  logic [2:0] ss_offset;
  int n_fail = 0;
  int num_checks = 0;

  scd_top uut (
    .CLOCK_I(clk), .SRST_I(srst), .CE_I(ce), .INT_OSC_TICK_I(int_tick),
    .EXT_OSC_TICK_I(ext_tick), .FACTORY_TRIM_I(trim), .SFR_ADDR_I(addr),
    .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
    .SYSCLK_TICK_O(sys_tick), .SRC_EXT_O(src_ext), .OSC_TRIM_O(osc_trim),
    .SS_OFFSET_O(ss_offset)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Checks: %0d, failures: %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    step();
    d = rdata;
    rd = 1'b0;
    step();
  endtask : rd_reg

  // Each source tick is a one-cycle pulse followed by an idle cycle.
  task automatic run_ticks(input int n, input logic ui, input logic ue, output int pulses);
    pulses = 0;
    for (int i = 0; i < n; i++)
    begin
      int_tick = ui;
      ext_tick = ue;
      step();
      pulses += int'(sys_tick === 1'b1);
      int_tick = 1'b0;
      ext_tick = 1'b0;
      step();
      pulses += int'(sys_tick === 1'b1);
    end
  endtask : run_ticks

  task automatic wait_ready();
    int p;
    int tk;
    logic [7:0] v;
    tk = 0;
    rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
    while (v[scd_pkg::SEL_READY_BIT] !== 1'b1 && tk <= 128)
    begin
      run_ticks(1, 1'b1, 1'b0, p);
      tk++;
      rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
    end
    chk(8'(tk <= 128), 8'h01);
    if (tk > 128)
    begin
      final_report();
    end
  endtask : wait_ready

  task automatic do_reset(input logic [7:0] t);
    logic [7:0] v;
    trim = t;
    srst = 1'b1;
    repeat (16) step();
    srst = 1'b0;
    chk(osc_trim, t);
    chk({5'h0, ss_offset}, 8'h00);
    chk({7'h0, src_ext}, 8'h00);
    rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
    chk(v, 8'h00);
    rd_reg(scd_pkg::ADDR_OSC_CONTROL, v);
    chk(v, 8'h00);
    rd_reg(scd_pkg::ADDR_OSC_CAL, v);
    chk(v, t);
  endtask : do_reset

  function automatic logic [2:0] ss_exp(input int k);
    int m;
    m = k % 12;
    return 3'((m <= 3) ? m : ((m <= 9) ? 6 - m : m - 12));
  endfunction : ss_exp

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int p;
    int tk;
    logic [7:0] v;
    logic [7:0] d;
    srst = 1'b1;
    ce = 1'b1;
    int_tick = 1'b0;
    ext_tick = 1'b0;
    trim = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(32'h4672d540));
    do_reset(8'($urandom));
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      wr_reg(scd_pkg::ADDR_OSC_CAL, d);
      rd_reg(scd_pkg::ADDR_OSC_CAL, v);
      chk(v, d);
      chk(osc_trim, d);
      d = 8'($urandom);
      wr_reg(scd_pkg::ADDR_OSC_CONTROL, d);
      rd_reg(scd_pkg::ADDR_OSC_CONTROL, v);
      chk(v, d & 8'h0B);
      d = 8'($urandom);
      d[0] = 1'b0;
      d[3] = 1'b0;
      wr_reg(scd_pkg::ADDR_CLOCK_SELECT, d);
      rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
      chk(v & 8'h7F, d & 8'h77);
    end
    // Unmapped places and a frozen clock enable leave registers alone.
    rd_reg(8'h00, v);
    chk(v, 8'h00);
    wr_reg(scd_pkg::ADDR_OSC_CONTROL, 8'h03);
    wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'h00);
    wait_ready();
    wr_reg(8'hBE, 8'hFF);
    rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
    chk(v, 8'h80);
    d = osc_trim;
    ce = 1'b0;
    wr_reg(scd_pkg::ADDR_OSC_CAL, ~d);
    ce = 1'b1;
    chk(osc_trim, d);
    // ----------------------------------------------------------------
    // Divider ratios, ready flag and the slowest-to-fastest change
    // ----------------------------------------------------------------
    for (int n = 0; n < 8; n++)
    begin
      wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'(n << 4));
      rd_reg(scd_pkg::ADDR_CLOCK_SELECT, v);
      chk({7'h0, v[7]}, 8'(n == 0));
      wait_ready();
      run_ticks(4 << n, 1'b1, 1'b0, p);
      chk(8'(p), 8'h04);
    end
    wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'h00);
    wait_ready();
    // ----------------------------------------------------------------
    // Internal oscillator post-scaler codes
    // ----------------------------------------------------------------
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(scd_pkg::ADDR_OSC_CONTROL, 8'(c));
      run_ticks(8, 1'b1, 1'b0, p);
      chk(8'(p), 8'((c == 3) ? 8 : (1 << c)));
    end
    // ----------------------------------------------------------------
    // Source switching and reserved source codes
    // ----------------------------------------------------------------
    wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'(scd_pkg::SRC_EXTERNAL));
    tk = 0;
    while (src_ext !== 1'b1 && tk < 8)
    begin
      run_ticks(1, 1'b1, 1'b1, p);
      tk++;
    end
    chk(8'(tk <= 3), 8'h01);
    if (tk >= 8)
    begin
      final_report();
    end
    run_ticks(4, 1'b1, 1'b0, p);
    chk(8'(p), 8'h00);
    run_ticks(4, 1'b0, 1'b1, p);
    chk(8'(p), 8'h04);
    for (int s = 2; s < 8; s++)
    begin
      wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'(s));
      run_ticks(3, 1'b1, 1'b1, p);
      chk({7'h0, src_ext}, 8'h01);
    end
    wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'h00);
    run_ticks(3, 1'b1, 1'b1, p);
    chk({7'h0, src_ext}, 8'h00);
    run_ticks(4, 1'b1, 1'b0, p);
    chk(8'(p), 8'h04);
    // ----------------------------------------------------------------
    // Spread spectrum dithering, sampled mid-step
    // ----------------------------------------------------------------
    wr_reg(scd_pkg::ADDR_OSC_CONTROL, 8'h0B);
    for (int k = 0; k < 24; k++)
    begin
      run_ticks(16, 1'b1, 1'b0, p);
      chk({5'h0, ss_offset}, {5'h0, ss_exp(k)});
      if (k < 23)
      begin
        run_ticks(16, 1'b1, 1'b0, p);
      end
    end
    wr_reg(scd_pkg::ADDR_OSC_CONTROL, 8'h03);
    chk({5'h0, ss_offset}, 8'h00);
    // A second reset with a busy configuration must restore defaults.
    wr_reg(scd_pkg::ADDR_OSC_CONTROL, 8'h0B);
    wr_reg(scd_pkg::ADDR_CLOCK_SELECT, 8'h51);
    run_ticks(40, 1'b1, 1'b1, p);
    do_reset(8'($urandom));
    final_report();
  end
endmodule : scd_top_tb
